/* spfc_checker.sv */
// Concurrent checks on the ports of the serial port flag control block.
`timescale 1ns/1ns
module spfc_checker
   import spfc_pkg::*;
#(
   parameter int unsigned DIV_HALF = 8,
   parameter int unsigned FIFO_DEPTH = 16
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Control.
   input wire logic transmit_enable,
   input wire logic receive_enable,
   input wire spfc_pkg::spfc_mode_type mode,
   input wire logic osc_wr,
   input wire logic osc_val,
   input wire logic flag_read,
   input wire logic [2:0] irq_mask,
   // Status.
   input wire logic sclk_oe,
   input wire logic transmit_trigger,
   input wire logic receive_trigger,
   input wire logic rx_error_flag,
   input wire logic rx_complete_flag,
   input wire logic tx_complete_flag,
   input wire logic [2:0] irq_req,
   input wire logic fast_oscillator
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   chk_err_first: assert property (
      $rose(rx_complete_flag) && rx_error_flag |-> $past(rx_error_flag))
      else $error("Error flag did not lead receive complete.");
   chk_osc_on_write: assert property (
      $rose(fast_oscillator) |-> $past(osc_wr) && $past(osc_val))
      else $error("Fast oscillator came on without a write.");
   chk_rx_flag_held: assert property (
      $fell(rx_complete_flag) |-> $past(flag_read))
      else $error("Receive complete flag cleared without a read.");
   chk_err_flag_held: assert property (
      $fell(rx_error_flag) || $fell(tx_complete_flag) |-> $past(flag_read))
      else $error("Factor flag cleared without a read.");
   chk_irq_masked: assert property (
      irq_req == $past({rx_error_flag, tx_complete_flag, rx_complete_flag} & irq_mask))
      else $error("Request does not follow flags and mask.");
   chk_sync_one_way: assert property (
      mode == SPFC_SYNC_MASTER || mode == SPFC_SYNC_SLAVE |-> !(transmit_trigger && receive_trigger))
      else $error("Both triggers high in clocked mode.");
   chk_tx_done_flag: assert property (
      $fell(transmit_trigger) && transmit_enable |-> tx_complete_flag)
      else $error("Transmit ended without its flag.");
   chk_rx_done_flag: assert property (
      $fell(receive_trigger) && receive_enable |-> rx_complete_flag || rx_error_flag)
      else $error("Receive ended without a flag.");
   chk_clk_drive: assert property (
      sclk_oe |-> $past(mode) == SPFC_SYNC_MASTER && $past(transmit_enable || receive_enable))
      else $error("Shift clock driven outside master mode.");
endmodule
bind spfc_serial_port spfc_checker #(.DIV_HALF(DIV_HALF), .FIFO_DEPTH(FIFO_DEPTH)) u_chk
(
   .mclk(mclk), .rst(rst), .transmit_enable(transmit_enable), .receive_enable(receive_enable),
   .mode(mode), .osc_wr(osc_wr), .osc_val(osc_val), .flag_read(flag_read), .irq_mask(irq_mask),
   .sclk_oe(sclk_oe), .transmit_trigger(transmit_trigger), .receive_trigger(receive_trigger),
   .rx_error_flag(rx_error_flag), .rx_complete_flag(rx_complete_flag),
   .tx_complete_flag(tx_complete_flag), .irq_req(irq_req), .fast_oscillator(fast_oscillator)
);

/* spfc_fifo.sv */
// Transmit data FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module spfc_fifo
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Fill side.
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic wr_valid,
   output logic wr_ready,
   // Drain side.
   output logic [WIDTH-1:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
         $error("FIFO depth must be a power of two of at least 2.");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic ready_q, ready_d;
   logic push, pop;

   assign push = wr_valid && ready_q;
   assign pop = rd_valid && rd_ready;
   assign wr_ready = ready_q;
   assign rd_valid = cnt_q != '0;
   assign rd_data = mem_q[rp_q];

   always_comb
   begin
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      ready_d = cnt_d != (AW+1)'(DEPTH);
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         ready_q <= 1'b0;
      end
      else
      begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         ready_q <= ready_d;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (push)
         mem_q[wp_q] <= wr_data;
   end
endmodule

/* spfc_pkg.sv */
// Shared constants and types of the serial port flag control block.
package spfc_pkg;
   localparam int unsigned SPFC_MCLK_HZ = 20000000;
   localparam int unsigned SPFC_DATA_W = 8;
   localparam int unsigned SPFC_FIFO_DEPTH = 16;
   localparam int unsigned SPFC_DIV_HALF = 8;
   localparam logic [2:0] SPFC_LAST7 = 3'h6;
   localparam logic [2:0] SPFC_LAST8 = 3'h7;
   localparam logic [2:0] SPFC_CNT_RST = 3'h0;
   localparam logic [7:0] SPFC_DATA_RST = 8'h00;
   localparam logic [2:0] SPFC_MASK_RST = 3'h0;

   typedef enum logic [1:0]
   {
      SPFC_SYNC_MASTER,
      SPFC_SYNC_SLAVE,
      SPFC_ASYNC7,
      SPFC_ASYNC8
   } spfc_mode_type;

   typedef enum logic [1:0]
   {
      SPFC_SRC_CPU,
      SPFC_SRC_TIMER,
      SPFC_SRC_OSC
   } spfc_src_type;

   typedef enum logic [2:0]
   {
      SPFC_IDLE,
      SPFC_START,
      SPFC_DATA,
      SPFC_PARITY,
      SPFC_STOP,
      SPFC_LEAD
   } spfc_state_type;
endpackage

/* spfc_remote.sv */
// Remote serial device: asynchronous sender and clocked receiver.
`timescale 1ns/1ns
module spfc_remote
(
   // Clock.
   input wire logic mclk,
   // Link.
   input wire logic sclk,
   input wire logic sclk_oe,
   input wire logic txd,
   output logic rxd
);
   logic [7:0] sh = 8'h00;
   logic sclk_prev = 1'b1;
   int cnt = 0;
   logic [7:0] got[$];
   initial rxd = 1'b1;
   // Sends one frame, least significant bit first; a low stop_ok breaks the stop bit.
   task automatic send(input logic [7:0] d, input int nbits, input logic stop_ok, input int bitc);
      rxd = 1'b0;
      repeat (bitc) @(posedge mclk);
      for (int i = 0; i < nbits; i++)
      begin
         #5 rxd = d[i];
         repeat (bitc) @(posedge mclk);
      end
      #5 rxd = stop_ok;
      repeat (bitc) @(posedge mclk);
      #5 rxd = 1'b1;
   endtask
   // Captures the transmit line on each rising shift clock edge.
   always @(posedge mclk)
   begin
      if (!sclk_oe)
         cnt = 0;
      else if (sclk && !sclk_prev)
      begin
         sh = {txd, sh[7:1]};
         cnt++;
         if (cnt == 8)
         begin
            got.push_back(sh);
            cnt = 0;
         end
      end
      sclk_prev = sclk;
   end
endmodule

/* spfc_serial_port.sv */
// Serial port with trigger, flag and overrun control.
//
// Contract
// - Synchronous mode shares one clock; one trigger, once set, refuses the other; writes to both in the same cycle set both.
// - Parity or framing error raises the error flag before receive complete.
// - Error lead is half a divided clock period, one timer underflow or one fast oscillator tick.
// - Overrun sets the error flag but no receive complete flag and no receive complete request.
// - Reset leaves the fast oscillator off.
// - Factor flags set on their condition regardless of the mask.
`timescale 1ns/1ns
module spfc_serial_port
   import spfc_pkg::*;
#(
   parameter int unsigned DIV_HALF = SPFC_DIV_HALF,
   parameter int unsigned FIFO_DEPTH = SPFC_FIFO_DEPTH
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Configuration.
   input wire logic transmit_enable,
   input wire logic receive_enable,
   input wire spfc_pkg::spfc_mode_type mode,
   input wire spfc_pkg::spfc_src_type clk_src,
   input wire logic parity_en,
   input wire logic parity_odd,
   input wire logic osc_wr,
   input wire logic osc_val,
   // Triggers and flags.
   input wire logic tx_trigger_wr,
   input wire logic rx_trigger_wr,
   input wire logic flag_read,
   input wire logic [2:0] irq_mask,
   // Transmit data.
   input wire logic [SPFC_DATA_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // Clock sources.
   input wire logic timer_underflow,
   input wire logic osc_tick,
   // Link.
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe,
   output logic txd,
   input wire logic rxd,
   // Status.
   output logic transmit_trigger,
   output logic receive_trigger,
   output logic rx_error_flag,
   output logic rx_complete_flag,
   output logic tx_complete_flag,
   output logic [2:0] irq_req,
   output logic [SPFC_DATA_W-1:0] rx_data,
   output logic fast_oscillator
);
   initial
   begin
      if (DIV_HALF < 1 || FIFO_DEPTH < 2)
         $error("Divider or FIFO depth out of range.");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clocking, synchronisers and FIFO.

   logic tick, sync_mode, master, fifo_valid, pop;
   logic [SPFC_DATA_W-1:0] fifo_data;
   logic [2:0] last;
   logic [2:0] sclk_s_q, rxd_s_q;
   logic sclk_f_q, sclk_f_d, sclk_p_q, rxd_f_q, rxd_f_d;
   logic sclk_q, sclk_d, oe_q, oe_d, osc_q, osc_d;
   logic rise, fall, xfer;

   assign sync_mode = mode == SPFC_SYNC_MASTER || mode == SPFC_SYNC_SLAVE;
   assign master = mode == SPFC_SYNC_MASTER;
   assign last = mode == SPFC_ASYNC7 ? SPFC_LAST7 : SPFC_LAST8;

   spfc_tick_gen #(.DIV_HALF(DIV_HALF)) u_tick
   (
      .mclk(mclk),
      .rst(rst),
      .src(clk_src),
      .run(transmit_enable || receive_enable),
      .osc_on(osc_q),
      .timer_underflow(timer_underflow),
      .osc_tick(osc_tick),
      .tick(tick)
   );

   spfc_fifo #(.WIDTH(SPFC_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .mclk(mclk),
      .rst(rst),
      .wr_data(tx_data),
      .wr_valid(tx_valid),
      .wr_ready(tx_ready),
      .rd_data(fifo_data),
      .rd_valid(fifo_valid),
      .rd_ready(pop)
   );

   always_comb
   begin
      sclk_f_d = sclk_s_q[1] == sclk_s_q[2] ? sclk_s_q[2] : sclk_f_q;
      rxd_f_d = rxd_s_q[1] == rxd_s_q[2] ? rxd_s_q[2] : rxd_f_q;
      osc_d = osc_wr ? osc_val : osc_q;
      oe_d = master && (transmit_enable || receive_enable);
      sclk_d = sclk_q;
      if (!master || !xfer)
         sclk_d = 1'b1;
      else if (tick)
         sclk_d = !sclk_q;
      if (master)
      begin
         rise = tick && xfer && !sclk_q;
         fall = tick && xfer && sclk_q;
      end
      else
      begin
         rise = sclk_f_q && !sclk_p_q;
         fall = !sclk_f_q && sclk_p_q;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sclk_s_q <= 3'h7;
         rxd_s_q <= 3'h7;
         sclk_f_q <= 1'b1;
         sclk_p_q <= 1'b1;
         rxd_f_q <= 1'b1;
         sclk_q <= 1'b1;
         oe_q <= 1'b0;
         osc_q <= 1'b0;
      end
      else
      begin
         sclk_s_q <= {sclk_s_q[1:0], sclk_in};
         rxd_s_q <= {rxd_s_q[1:0], rxd};
         sclk_f_q <= sclk_f_d;
         sclk_p_q <= sclk_f_q;
         rxd_f_q <= rxd_f_d;
         sclk_q <= sclk_d;
         oe_q <= oe_d;
         osc_q <= osc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter.

   spfc_state_type tx_st_q, tx_st_d;
   logic [SPFC_DATA_W-1:0] tx_sh_q, tx_sh_d;
   logic [2:0] tx_cnt_q, tx_cnt_d;
   logic tx_ph_q, tx_ph_d, txd_q, txd_d, tx_par_q, tx_par_d, tx_done;
   logic tx_trig_q, tx_trig_d;

   always_comb
   begin
      tx_st_d = tx_st_q;
      tx_sh_d = tx_sh_q;
      tx_cnt_d = tx_cnt_q;
      tx_ph_d = tx_ph_q;
      txd_d = txd_q;
      tx_par_d = tx_par_q;
      tx_done = 1'b0;
      pop = 1'b0;
      case (tx_st_q)
         SPFC_IDLE:
         begin
            txd_d = 1'b1;
            if (tx_trig_q && fifo_valid)
            begin
               pop = 1'b1;
               tx_sh_d = fifo_data;
               tx_cnt_d = SPFC_CNT_RST;
               tx_par_d = parity_odd;
               tx_ph_d = 1'b0;
               tx_st_d = sync_mode ? SPFC_DATA : SPFC_START;
               txd_d = sync_mode;
            end
         end
         SPFC_START:
         begin
            if (tick)
            begin
               tx_ph_d = !tx_ph_q;
               if (tx_ph_q)
               begin
                  txd_d = tx_sh_q[0];
                  tx_st_d = SPFC_DATA;
               end
            end
         end
         SPFC_DATA:
         begin
            if (sync_mode)
            begin
               if (fall)
                  txd_d = tx_sh_q[0];
               if (rise)
               begin
                  tx_sh_d = tx_sh_q >> 1;
                  tx_cnt_d = tx_cnt_q + 1'b1;
                  if (tx_cnt_q == SPFC_LAST8)
                  begin
                     tx_done = 1'b1;
                     tx_st_d = SPFC_IDLE;
                  end
               end
            end
            else if (tick)
            begin
               tx_ph_d = !tx_ph_q;
               if (tx_ph_q)
               begin
                  tx_par_d = tx_par_q ^ tx_sh_q[0];
                  tx_sh_d = tx_sh_q >> 1;
                  tx_cnt_d = tx_cnt_q + 1'b1;
                  txd_d = tx_sh_q[1];
                  if (tx_cnt_q == last)
                  begin
                     tx_st_d = parity_en ? SPFC_PARITY : SPFC_STOP;
                     txd_d = parity_en ? tx_par_q ^ tx_sh_q[0] : 1'b1;
                  end
               end
            end
         end
         SPFC_PARITY:
         begin
            if (tick)
            begin
               tx_ph_d = !tx_ph_q;
               if (tx_ph_q)
               begin
                  txd_d = 1'b1;
                  tx_st_d = SPFC_STOP;
               end
            end
         end
         SPFC_STOP:
         begin
            if (tick)
            begin
               tx_ph_d = !tx_ph_q;
               if (tx_ph_q)
               begin
                  tx_done = 1'b1;
                  tx_st_d = SPFC_IDLE;
               end
            end
         end
         default: tx_st_d = SPFC_IDLE;
      endcase
      if (!transmit_enable)
         tx_st_d = SPFC_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver.

   spfc_state_type rx_st_q, rx_st_d;
   logic [SPFC_DATA_W-1:0] rx_sh_q, rx_sh_d, rx_data_q, rx_data_d;
   logic [2:0] rx_cnt_q, rx_cnt_d;
   logic rx_ph_q, rx_ph_d, rx_par_q, rx_par_d, perr_q, perr_d;
   logic rx_trig_q, rx_trig_d, rx_end, set_err, set_cpl;
   logic rx_errf_q, rx_errf_d, rx_cplf_q, rx_cplf_d, tx_cplf_q, tx_cplf_d;

   always_comb
   begin
      rx_st_d = rx_st_q;
      rx_sh_d = rx_sh_q;
      rx_cnt_d = rx_cnt_q;
      rx_ph_d = rx_ph_q;
      rx_par_d = rx_par_q;
      perr_d = perr_q;
      rx_data_d = rx_data_q;
      rx_end = 1'b0;
      set_err = 1'b0;
      set_cpl = 1'b0;
      case (rx_st_q)
         SPFC_IDLE:
         begin
            if (rx_trig_q && (sync_mode || !rxd_f_q))
            begin
               rx_cnt_d = SPFC_CNT_RST;
               rx_ph_d = 1'b0;
               rx_par_d = parity_odd;
               perr_d = 1'b0;
               rx_st_d = sync_mode ? SPFC_DATA : SPFC_START;
            end
         end
         SPFC_START:
         begin
            if (tick)
               rx_st_d = rxd_f_q ? SPFC_IDLE : SPFC_DATA;
         end
         SPFC_DATA:
         begin
            if (sync_mode ? rise : tick && rx_ph_q)
            begin
               rx_sh_d = {rxd_f_q, rx_sh_q[SPFC_DATA_W-1:1]};
               rx_par_d = rx_par_q ^ rxd_f_q;
               rx_cnt_d = rx_cnt_q + 1'b1;
               if (sync_mode && rx_cnt_q == SPFC_LAST8)
               begin
                  rx_end = 1'b1;
                  rx_st_d = SPFC_IDLE;
               end
               else if (!sync_mode && rx_cnt_q == last)
                  rx_st_d = parity_en ? SPFC_PARITY : SPFC_STOP;
            end
            if (!sync_mode && tick)
               rx_ph_d = !rx_ph_q;
         end
         SPFC_PARITY:
         begin
            if (tick)
            begin
               rx_ph_d = !rx_ph_q;
               if (rx_ph_q)
               begin
                  perr_d = rx_par_q ^ rxd_f_q;
                  rx_st_d = SPFC_STOP;
               end
            end
         end
         SPFC_STOP:
         begin
            if (tick)
            begin
               rx_ph_d = !rx_ph_q;
               if (rx_ph_q)
               begin
                  rx_end = 1'b1;
                  rx_st_d = SPFC_IDLE;
                  if (perr_q || !rxd_f_q)
                  begin
                     set_err = 1'b1;
                     rx_st_d = SPFC_LEAD;
                  end
               end
            end
         end
         SPFC_LEAD:
         begin
            if (tick)
            begin
               set_cpl = 1'b1;
               rx_st_d = SPFC_IDLE;
            end
         end
         default: rx_st_d = SPFC_IDLE;
      endcase
      if (rx_end)
      begin
         rx_data_d = last == SPFC_LAST7 ? {1'b0, rx_sh_d[SPFC_DATA_W-1:1]} : rx_sh_d;
         if (rx_cplf_q && !flag_read)
         begin
            set_err = 1'b1;
            rx_st_d = SPFC_IDLE;
         end
         else if (rx_st_d == SPFC_IDLE)
            set_cpl = 1'b1;
      end
      if (!receive_enable)
         rx_st_d = SPFC_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Triggers, factor flags and registers.

   logic [2:0] irq_q, irq_d;

   assign xfer = sync_mode && (tx_st_q == SPFC_DATA || rx_st_q == SPFC_DATA);

   always_comb
   begin
      tx_trig_d = tx_trig_q;
      rx_trig_d = rx_trig_q;
      if (tx_trigger_wr && !tx_trig_q && !(sync_mode && rx_trig_q))
         tx_trig_d = 1'b1;
      if (rx_trigger_wr && !rx_trig_q && !(sync_mode && tx_trig_q))
         rx_trig_d = 1'b1;
      if (tx_done || !transmit_enable)
         tx_trig_d = 1'b0;
      if (rx_end || !receive_enable)
         rx_trig_d = 1'b0;
      rx_errf_d = set_err || (rx_errf_q && !flag_read);
      rx_cplf_d = set_cpl || (rx_cplf_q && !flag_read);
      tx_cplf_d = tx_done || (tx_cplf_q && !flag_read);
      irq_d = {rx_errf_q, tx_cplf_q, rx_cplf_q} & irq_mask;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         tx_st_q <= SPFC_IDLE;
         tx_sh_q <= SPFC_DATA_RST;
         tx_cnt_q <= SPFC_CNT_RST;
         tx_ph_q <= 1'b0;
         txd_q <= 1'b1;
         tx_par_q <= 1'b0;
         rx_st_q <= SPFC_IDLE;
         rx_sh_q <= SPFC_DATA_RST;
         rx_data_q <= SPFC_DATA_RST;
         rx_cnt_q <= SPFC_CNT_RST;
         rx_ph_q <= 1'b0;
         rx_par_q <= 1'b0;
         perr_q <= 1'b0;
         tx_trig_q <= 1'b0;
         rx_trig_q <= 1'b0;
         rx_errf_q <= 1'b0;
         rx_cplf_q <= 1'b0;
         tx_cplf_q <= 1'b0;
         irq_q <= SPFC_MASK_RST;
      end
      else
      begin
         tx_st_q <= tx_st_d;
         tx_sh_q <= tx_sh_d;
         tx_cnt_q <= tx_cnt_d;
         tx_ph_q <= tx_ph_d;
         txd_q <= txd_d;
         tx_par_q <= tx_par_d;
         rx_st_q <= rx_st_d;
         rx_sh_q <= rx_sh_d;
         rx_data_q <= rx_data_d;
         rx_cnt_q <= rx_cnt_d;
         rx_ph_q <= rx_ph_d;
         rx_par_q <= rx_par_d;
         perr_q <= perr_d;
         tx_trig_q <= tx_trig_d;
         rx_trig_q <= rx_trig_d;
         rx_errf_q <= rx_errf_d;
         rx_cplf_q <= rx_cplf_d;
         tx_cplf_q <= tx_cplf_d;
         irq_q <= irq_d;
      end
   end

   assign sclk_out = sclk_q;
   assign sclk_oe = oe_q;
   assign txd = txd_q;
   assign transmit_trigger = tx_trig_q;
   assign receive_trigger = rx_trig_q;
   assign rx_error_flag = rx_errf_q;
   assign rx_complete_flag = rx_cplf_q;
   assign tx_complete_flag = tx_cplf_q;
   assign irq_req = irq_q;
   assign rx_data = rx_data_q;
   assign fast_oscillator = osc_q;
endmodule

/* spfc_tick_gen.sv */
// Half-bit tick generator for the three serial clock sources.
`timescale 1ns/1ns
module spfc_tick_gen
   import spfc_pkg::*;
#(
   parameter int unsigned DIV_HALF = 8
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Source selection.
   input wire spfc_pkg::spfc_src_type src,
   input wire logic run,
   input wire logic osc_on,
   // Source pulses.
   input wire logic timer_underflow,
   input wire logic osc_tick,
   // Half-bit tick.
   output logic tick
);
   localparam int unsigned CW = $clog2(DIV_HALF + 1);

   initial
   begin
      if (DIV_HALF < 1)
         $error("Divider must be at least 1.");
   end

   logic [CW-1:0] cnt_q, cnt_d;
   logic tick_q, tick_d;

   assign tick = tick_q;

   always_comb
   begin
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (!run)
         cnt_d = '0;
      else
      begin
         case (src)
            SPFC_SRC_CPU:
            begin
               if (cnt_q == CW'(DIV_HALF - 1))
               begin
                  cnt_d = '0;
                  tick_d = 1'b1;
               end
               else
                  cnt_d = cnt_q + 1'b1;
            end
            SPFC_SRC_TIMER: tick_d = timer_underflow;
            SPFC_SRC_OSC: tick_d = osc_tick && osc_on;
            default: tick_d = 1'b0;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
endmodule

/* tb.sv */
// Self-checking bench of the serial port flag control block.
`timescale 1ns/1ns
module tb;
   import spfc_pkg::*;
   localparam int unsigned DIVH = 4;
   localparam int TPER = 5;
   localparam logic [3:0] TXW = 4'h1, RXW = 4'h2, RDW = 4'h4, OSW = 4'h8;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic transmit_enable = 1'b0;
   logic receive_enable = 1'b0;
   spfc_mode_type mode = SPFC_ASYNC8;
   spfc_src_type clk_src = SPFC_SRC_CPU;
   logic osc_val = 1'b0;
   logic par = 1'b0;
   logic [3:0] wr = 4'h0;
   logic [2:0] irq_mask = 3'h0;
   logic [7:0] tx_data = 8'h00;
   logic tx_valid = 1'b0;
   logic timer_underflow = 1'b0;
   logic osc_tick = 1'b0;
   logic sclk_line, rxd, tx_ready, sclk_out, sclk_oe, txd, transmit_trigger, receive_trigger;
   logic rx_error_flag, rx_complete_flag, tx_complete_flag, fast_oscillator;
   logic [2:0] irq_req;
   logic [7:0] rx_data;
   logic [5:0] sts;
   logic [2:0] fl;
   int miscompares = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;
   assign sclk_line = sclk_oe ? sclk_out : 1'b1;
   assign sts = {fast_oscillator, transmit_trigger, receive_trigger, rx_error_flag,
      tx_complete_flag, rx_complete_flag};
   always #25 mclk = ~mclk;
   spfc_serial_port #(.DIV_HALF(DIVH), .FIFO_DEPTH(16)) uut
   (
      .mclk(mclk), .rst(rst), .transmit_enable(transmit_enable), .receive_enable(receive_enable),
      .mode(mode), .clk_src(clk_src), .parity_en(par), .parity_odd(1'b0), .osc_wr(wr[3]),
      .osc_val(osc_val), .tx_trigger_wr(wr[0]), .rx_trigger_wr(wr[1]), .flag_read(wr[2]),
      .irq_mask(irq_mask), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .timer_underflow(timer_underflow), .osc_tick(osc_tick), .sclk_in(sclk_line),
      .sclk_out(sclk_out), .sclk_oe(sclk_oe), .txd(txd), .rxd(rxd),
      .transmit_trigger(transmit_trigger), .receive_trigger(receive_trigger),
      .rx_error_flag(rx_error_flag), .rx_complete_flag(rx_complete_flag),
      .tx_complete_flag(tx_complete_flag), .irq_req(irq_req), .rx_data(rx_data),
      .fast_oscillator(fast_oscillator)
   );
   spfc_remote far (.mclk(mclk), .sclk(sclk_line), .sclk_oe(sclk_oe), .txd(txd), .rxd(rxd));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (miscompares == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #5;
   endtask
   task automatic pulse(input logic [3:0] m);
      wr = m;
      tick(1);
      wr = 4'h0;
      tick(1);
   endtask
   task automatic read_flags(output logic [2:0] f);
      f = sts[2:0];
      pulse(RDW);
   endtask
   // Waits for one status bit to reach a level and counts the cycles taken.
   task automatic wait_for(input int idx, input logic v, output int k);
      k = 0;
      while (sts[idx] !== v && k < 3000)
      begin
         tick(1);
         k++;
      end
      chk({7'h00, sts[idx]}, {7'h00, v});
   endtask
   // Ticks of the timer and fast oscillator sources, and the run limit.
   always
   begin
      @(posedge mclk);
      #5;
      cyc++;
      timer_underflow = (cyc % TPER == 0);
      osc_tick = (cyc % 2 == 1);
      if (cyc > 20000)
      begin
         miscompares++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      tick(20);
      rst = 1'b0;
      tick(2);
      chk({2'h0, sts}, 8'h00);
      for (int m = 0; m < 2; m++)
      begin
         receive_enable = 1'b0;
         tick(1);
         mode = m ? SPFC_ASYNC7 : SPFC_ASYNC8;
         tick(1);
         receive_enable = 1'b1;
         pulse(RXW);
         chk({7'h00, receive_trigger}, 8'h01);
         far.send(8'hA5, m ? 7 : 8, 1'b1, 2 * DIVH);
         wait_for(3, 1'b0, n);
         chk(rx_data, m ? 8'h25 : 8'hA5);
         chk({5'h00, irq_req}, 8'h00);
         read_flags(fl);
         chk({5'h00, fl}, 8'h01);
         chk({5'h00, sts[2:0]}, 8'h00);
      end
      for (int s = 0; s < 2; s++)
      begin
         receive_enable = 1'b0;
         tick(1);
         clk_src = s ? SPFC_SRC_TIMER : SPFC_SRC_CPU;
         par = !s;
         tick(1);
         receive_enable = 1'b1;
         pulse(RXW);
         fork
            far.send(8'h5A, 7, !s, s ? 2 * TPER : 2 * DIVH);
         join_none
         wait_for(2, 1'b1, n);
         chk({7'h00, rx_complete_flag}, 8'h00);
         wait_for(0, 1'b1, n);
         chk(8'(n), s ? 8'(TPER) : 8'(DIVH));
         tick(4 * TPER);
         read_flags(fl);
         chk({5'h00, fl}, 8'h05);
      end
      irq_mask = 3'h1;
      for (int i = 0; i < 2; i++)
      begin
         pulse(RXW);
         far.send(8'h3C + 8'(i), 7, 1'b1, 2 * TPER);
      end
      chk({5'h00, sts[2:0]}, 8'h05);
      chk({5'h00, irq_req}, 8'h01);
      chk(rx_data, 8'h3D);
      read_flags(fl);
      tick(10);
      chk({2'h0, sts[2:0], irq_req}, 8'h00);
      receive_enable = 1'b0;
      tick(1);
      mode = SPFC_SYNC_MASTER;
      clk_src = SPFC_SRC_CPU;
      irq_mask = 3'h2;
      for (int i = 0; i < 17; i++)
      begin
         chk({7'h00, tx_ready}, i < 16 ? 8'h01 : 8'h00);
         tx_data = 8'h80 + 8'(i);
         tx_valid = 1'b1;
         tick(1);
      end
      tx_valid = 1'b0;
      transmit_enable = 1'b1;
      receive_enable = 1'b1;
      tick(1);
      for (int i = 0; i < 16; i++)
      begin
         pulse(TXW);
         if (i == 0)
         begin
            pulse(RXW);
            chk({7'h00, receive_trigger}, 8'h00);
         end
         wait_for(4, 1'b0, n);
         chk({7'h00, tx_complete_flag}, 8'h01);
         tick(1);
         chk({5'h00, irq_req}, 8'h02);
         chk(far.got.pop_front(), 8'h80 + 8'(i));
         read_flags(fl);
         chk({5'h00, fl}, 8'h02);
      end
      chk({7'h00, tx_ready}, 8'h01);
      transmit_enable = 1'b0;
      receive_enable = 1'b0;
      tick(1);
      clk_src = SPFC_SRC_OSC;
      tick(1);
      transmit_enable = 1'b1;
      tx_data = 8'hC3;
      tx_valid = 1'b1;
      tick(1);
      tx_valid = 1'b0;
      pulse(TXW);
      tick(100);
      chk({7'h00, transmit_trigger}, 8'h01);
      osc_val = 1'b1;
      pulse(OSW);
      chk({7'h00, fast_oscillator}, 8'h01);
      wait_for(4, 1'b0, n);
      tick(1);
      chk(far.got.pop_front(), 8'hC3);
      test_done();
   end
endmodule
